// ---- payload_command_config_idle.sv ----
`timescale 1ns/1ps
`include "pcmd_cfg.svh"

module payload_command_config_idle #(
  parameter int DEPTH        = 16,
  parameter int STATUS_TICKS = `STATUS_MS * 1000
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              path_sel_i,
  output pcmd_pkg::cmd_out_t     cmd_o
);
  import pcmd_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam cfg_t CFG_DEF = '{w4: `DEF_W4, w3: `DEF_W3, w2: `DEF_W2,
                               w1: `DEF_W1, w0: `DEF_W0};

  generate
    if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
      $error("DEPTH must lie between 2 and 256");
    end
    if (STATUS_TICKS < 2 || STATUS_TICKS >= (1 << 17)) begin : g_bad_stat
      $error("STATUS_TICKS out of range");
    end
  endgenerate

  cfg_t              active_r;
  logic [15:0]       cfg_buf_r [0:`CFG_WORDS-2];
  logic [2:0]        cfg_cnt_r;
  logic              cfg_bad_r;
  logic [15:0]       vmask_r;
  logic [15:0]       vmatch_r;
  logic [15:0]       cmd_mem_r [0:DEPTH-1];
  logic [AW:0]       cmd_cnt_r;
  logic              cmd_bad_r;
  logic              go_pend_r;
  logic              rej_r;
  logic              fresh_r;
  cfg_t              snap_r;
  logic [16:0]       stat_cnt_r;
  logic [6:0]        tick_cnt_r;
  logic              tick_r;
  logic [15:0]       bit_cnt_r;
  logic [15:0]       tx_per_r;
  tx_state_t         state_r;
  logic [AW:0]       widx_r;
  logic [3:0]        bidx_r;
  logic [AW:0]       tx_len_r;
  logic              fill_bit_r;
  logic [11:0]       sc_cnt_r;
  logic              sc_r;
  logic              sync1_r;
  logic              sync2_r;
  logic              sync3_r;
  logic              sel_b_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  cmd_out_t          out_r;

  logic              req;
  logic              wr;
  logic              rd;
  logic [15:0]       wword;
  logic              word_ok;
  logic              cfg_wr;
  logic              cfg_last;
  cfg_t              cfg_new;
  logic              cfg_ok;
  logic              cfg_rej;
  logic              busy;
  logic              cmd_wr;
  logic              go_wr;
  logic              go_ok;
  logic              go_rej;
  logic              drop_cmd;
  logic [15:0]       cur_per;
  logic              bit_stb;
  logic              half;
  logic              line;
  logic              snap_stb;
  logic [15:0]       cur_word;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = req & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
  assign rd       = req & ~wb_we_i;
  assign wword    = wb_dat_i[15:0];
  assign busy     = (state_r == TX_SEND) | go_pend_r;
  assign word_ok  = (wword & vmask_r) == vmatch_r;
  assign cfg_wr   = wr & (wb_adr_i == `A_CFG_WORD);
  assign cfg_last = cfg_wr & (cfg_cnt_r == `LAST_CFG_IDX);
  assign cfg_new  = '{w4: wword, w3: cfg_buf_r[3], w2: cfg_buf_r[2],
                      w1: cfg_buf_r[1], w0: cfg_buf_r[0]};
  assign cfg_rej  = cfg_last & (cfg_bad_r | ~word_ok |
                    (busy & (cfg_new != active_r)));
  assign cfg_ok   = cfg_last & ~cfg_rej;
  assign cmd_wr   = wr & (wb_adr_i == `A_CMD_WORD) & ~busy;
  assign go_wr    = wr & (wb_adr_i == `A_CMD_CTRL) & wb_dat_i[`F_CTL_GO] & ~busy;
  assign go_ok    = go_wr & ~cmd_bad_r & (cmd_cnt_r != '0);
  assign go_rej   = go_wr & ~go_ok;
  assign drop_cmd = cfg_rej | go_rej;
  assign cur_per  = (state_r == TX_OFF) ? active_r.w1 : tx_per_r;
  // Periods of 0 or 1 both give one-tick bits instead of wrapping the compare.
  assign bit_stb  = tick_r & ((cur_per <= 16'h0001) | (bit_cnt_r >= cur_per - 16'h0001));
  assign half     = bit_cnt_r >= {1'b0, cur_per[15:1]};
  assign snap_stb = tick_r & (stat_cnt_r == 17'(STATUS_TICKS - 1));
  assign cur_word = cmd_mem_r[widx_r[AW-1:0]];

  // Wishbone answer: one-cycle ack after the request.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        `A_CFG_WORD:  rdat_r <= {29'h0, cfg_cnt_r};
        `A_CMD_WORD:  rdat_r <= 32'(cmd_cnt_r);
        `A_CMD_CTRL:  rdat_r <= {29'h0, fresh_r, rej_r, busy};
        `A_VAL_MASK:  rdat_r <= {16'h0, vmask_r};
        `A_VAL_MATCH: rdat_r <= {16'h0, vmatch_r};
        `A_STATUS0:   rdat_r <= {16'h0, snap_r.w0};
        `A_STATUS1:   rdat_r <= {16'h0, snap_r.w1};
        `A_STATUS2:   rdat_r <= {16'h0, snap_r.w2};
        `A_STATUS3:   rdat_r <= {16'h0, snap_r.w3};
        `A_STATUS4:   rdat_r <= {16'h0, snap_r.w4};
        default:      rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vmask_r  <= 16'h0000;
      vmatch_r <= 16'h0000;
    end else begin
      if (wr && wb_adr_i == `A_VAL_MASK) begin
        vmask_r <= wword;
      end
      if (wr && wb_adr_i == `A_VAL_MATCH) begin
        vmatch_r <= wword;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_cnt_r <= 3'h0;
      cfg_bad_r <= 1'b0;
    end else if (cfg_wr) begin
      if (cfg_last) begin
        cfg_cnt_r <= 3'h0;
        cfg_bad_r <= 1'b0;
      end else begin
        cfg_buf_r[cfg_cnt_r[1:0]] <= wword;
        cfg_cnt_r <= cfg_cnt_r + 3'h1;
        cfg_bad_r <= cfg_bad_r | ~word_ok;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_r <= CFG_DEF;
    end else if (cfg_ok) begin
      active_r <= cfg_new.w0[`F_REINIT] ? CFG_DEF : cfg_new;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_cnt_r <= '0;
      cmd_bad_r <= 1'b0;
    end else if (drop_cmd || (state_r == TX_SEND && bit_stb &&
                 widx_r == tx_len_r - 1'b1 && bidx_r == 4'h0)) begin
      cmd_cnt_r <= '0;
      cmd_bad_r <= 1'b0;
    end else if (cmd_wr) begin
      if (cmd_cnt_r == (AW+1)'(DEPTH)) begin
        cmd_bad_r <= 1'b1;
      end else begin
        cmd_mem_r[cmd_cnt_r[AW-1:0]] <= wword;
        cmd_cnt_r <= cmd_cnt_r + 1'b1;
        cmd_bad_r <= cmd_bad_r | ~word_ok;
      end
    end
  end

  // Rejection flag: a new rejection wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rej_r <= 1'b0;
    end else if (drop_cmd) begin
      rej_r <= 1'b1;
    end else if (wr && wb_adr_i == `A_CMD_CTRL && wb_dat_i[`F_CTL_CLR]) begin
      rej_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= tick_cnt_r == 7'(`TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == 7'(`TICK_CYC - 1)) ? 7'h00 : tick_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stat_cnt_r <= 17'h00000;
      snap_r     <= CFG_DEF;
    end else if (tick_r) begin
      stat_cnt_r <= snap_stb ? 17'h00000 : stat_cnt_r + 17'h00001;
      if (snap_stb) begin
        snap_r <= active_r;
        snap_r.w0[`F_ST_BUSY] <= busy;
        snap_r.w0[`F_ST_REJ]  <= rej_r;
      end
    end
  end

  // Fresh snapshot flag; the set wins over the clear by a status read.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fresh_r <= 1'b0;
    end else if (snap_stb) begin
      fresh_r <= 1'b1;
    end else if (rd && wb_adr_i == `A_STATUS0) begin
      fresh_r <= 1'b0;
    end
  end

  // Bit timing runs continuously so fill and message share boundaries.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bit_cnt_r <= 16'h0000;
    end else if (tick_r) begin
      bit_cnt_r <= bit_stb ? 16'h0000 : bit_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      go_pend_r <= 1'b0;
    end else if (drop_cmd) begin
      go_pend_r <= 1'b0;
    end else if (go_ok) begin
      go_pend_r <= 1'b1;
    end else if (bit_stb && state_r != TX_SEND) begin
      go_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r    <= TX_OFF;
      widx_r     <= '0;
      bidx_r     <= 4'hF;
      tx_len_r   <= '0;
      tx_per_r   <= `DEF_W1;
      fill_bit_r <= 1'b1;
    end else if (cfg_rej && state_r == TX_SEND) begin
      state_r <= TX_OFF;
    end else if (bit_stb) begin
      case (state_r)
        TX_OFF, TX_FILL: begin
          fill_bit_r <= ~fill_bit_r;
          if (go_pend_r) begin
            state_r  <= TX_SEND;
            widx_r   <= '0;
            bidx_r   <= 4'hF;
            tx_len_r <= cmd_cnt_r;
            tx_per_r <= active_r.w1;
          end
        end
        TX_SEND: begin
          if (bidx_r != 4'h0) begin
            bidx_r <= bidx_r - 4'h1;
          end else if (widx_r != tx_len_r - 1'b1) begin
            bidx_r <= 4'hF;
            widx_r <= widx_r + 1'b1;
          end else begin
            fill_bit_r <= 1'b1;
            state_r    <= active_r.w0[`F_IDLE_EN] ? TX_FILL : TX_OFF;
          end
        end
        default: state_r <= TX_OFF;
      endcase
    end
  end

  // 16 kHz subcarrier, square-wave approximation of the sine tone.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sc_cnt_r <= 12'h000;
      sc_r     <= 1'b0;
    end else if (sc_cnt_r == 12'(`SUBC_HALF_CYC - 1)) begin
      sc_cnt_r <= 12'h000;
      sc_r     <= ~sc_r;
    end else begin
      sc_cnt_r <= sc_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      sel_b_r <= 1'b0;
    end else begin
      sync1_r <= path_sel_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        sel_b_r <= sync3_r;
      end
    end
  end

  always_comb begin
    case (state_r)
      TX_SEND: line = cur_word[bidx_r];
      TX_FILL: line = fill_bit_r;
      default: line = 1'b0;
    endcase
    if (active_r.w0[`F_BIPHASE] && state_r != TX_OFF) begin
      line = line ^ half;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_r <= '0;
    end else begin
      out_r.a     <= line;
      out_r.b     <= line;
      out_r.rf    <= line;
      out_r.rf_en <= active_r.w0[`F_DETACHED];
      out_r.a_en  <= ~active_r.w0[`F_DETACHED] & ~sel_b_r;
      out_r.b_en  <= ~active_r.w0[`F_DETACHED] & sel_b_r;
      out_r.subc  <= (state_r == TX_SEND || active_r.w0[`F_SC_MOD]) ? sc_r ^ line : sc_r;
      out_r.subc_en    <= active_r.w0[`F_SC_OUT_EN];
      out_r.subc_in_en <= active_r.w0[`F_SC_IN_EN];
    end
  end

  assign cmd_o    = out_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  a_ack_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_r |=> !ack_r) else $error("ack held two cycles");
  a_cfg_apply: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_ok && !cfg_new.w0[`F_REINIT] |=> active_r == $past(cfg_new))
    else $error("config not applied");
  a_reinit_def: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_ok && cfg_new.w0[`F_REINIT] |=> active_r == CFG_DEF)
    else $error("reinit did not restore defaults");
  a_reject_all: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_rej |=> active_r == $past(active_r) && cmd_cnt_r == '0 && rej_r)
    else $error("rejected message had effect");
  a_busy_change: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_last && state_r == TX_SEND && cfg_new != active_r |=> state_r == TX_OFF)
    else $error("send survived changed config");
  a_one_path: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(out_r.a_en && out_r.b_en) && !(out_r.rf_en && (out_r.a_en || out_r.b_en)))
    else $error("two command paths active");
  a_idle_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_r == TX_FILL && $past(state_r) == TX_SEND |-> fill_bit_r)
    else $error("idle did not start with one");
  a_idle_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_r == TX_FILL |-> cur_per == tx_per_r && $stable(tx_per_r))
    else $error("idle rate changed");
  a_stat_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(snap_r) |-> $past(snap_stb)) else $error("status updated early");
  a_reset_def: assert property (@(posedge core_clk_i)
    $past(rst_i) && !rst_i |-> active_r == CFG_DEF) else $error("no default after reset");
  a_bad_word: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_wr && !cfg_last && !word_ok |=> cfg_bad_r) else $error("bad word not marked");

  c_cfg_applied: cover property (@(posedge core_clk_i) disable iff (rst_i) cfg_ok);
  c_send_fill: cover property (@(posedge core_clk_i) disable iff (rst_i)
    state_r == TX_SEND ##1 state_r == TX_FILL);
  c_fill_send: cover property (@(posedge core_clk_i) disable iff (rst_i)
    state_r == TX_FILL ##1 state_r == TX_SEND);
  c_rejected: cover property (@(posedge core_clk_i) disable iff (rst_i) cfg_rej);
endmodule

// ---- payload_command_config_idle_test.sv ----
`timescale 1ns/1ps
`include "pcmd_cfg.svh"
module payload_command_config_idle_test;
  import pcmd_pkg::*;

  localparam int LIMIT = 60000;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        use_b = 1'b0;
  logic        path_sel;
  logic        line;
  cmd_out_t    cmd;
  logic [31:0] q;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  cfg_t        dflt;

  assign dflt = {`DEF_W4, `DEF_W3, `DEF_W2, `DEF_W1, `DEF_W0};

  always #5 clk = ~clk;

  payload_command_config_idle #(.DEPTH(16), .STATUS_TICKS(20)) dut (
    .core_clk_i (clk),
    .rst_i      (rst),
    .wb_cyc_i   (cyc),
    .wb_stb_i   (stb),
    .wb_we_i    (we),
    .wb_adr_i   (adr),
    .wb_sel_i   (sel),
    .wb_dat_i   (wdat),
    .wb_dat_o   (rdat),
    .wb_ack_o   (ack),
    .path_sel_i (path_sel),
    .cmd_o      (cmd)
  );

  vehicle_equip_model equip (
    .core_clk_i (clk),
    .use_b_i    (use_b),
    .cmd_i      (cmd),
    .path_sel_o (path_sel),
    .line_o     (line)
  );

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request stays up until ack is sampled high; read data is taken at that edge.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic cfg(input cfg_t c);
    for (int i = 0; i < `CFG_WORDS; i++) begin
      xfer(`A_CFG_WORD, 1'b1, c[i*16 +: 16]);
    end
  endtask

  // Clears the fresh flag, then waits for the next snapshot so status shows the live setup.
  task automatic fresh_status();
    int n;
    xfer(`A_STATUS0, 1'b0, 16'h0000);
    n = 0;
    q = 32'h0000_0000;
    while (q[`F_CTL_FRESH] !== 1'b1 && n < 1000) begin
      xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
      n++;
    end
    chk("fresh flag", 32'h1, 32'(q[`F_CTL_FRESH]));
  endtask

  task automatic check_status(input cfg_t e);
    for (int i = 0; i < `CFG_WORDS; i++) begin
      xfer(`A_STATUS0 + 8'(4 * i), 1'b0, 16'h0000);
      chk("status word", {16'h0000, e[i*16 +: 16]}, q);
    end
  endtask

  function automatic logic [31:0] pins();
    return {27'h0, cmd.a_en, cmd.b_en, cmd.rf_en, cmd.subc_en, cmd.subc_in_en};
  endfunction

  // The outputs leave reset one edge after release and are read one edge later.
  task automatic t_defaults();
    repeat (2) @(posedge clk);
    chk("enables after reset", 32'h10, pins());
    fresh_status();
    check_status(dflt);
  endtask

  task automatic t_path();
    use_b <= 1'b1;
    repeat (10) @(posedge clk);
    chk("path b enables", 32'h08, pins());
    use_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk("path a enables", 32'h10, pins());
  endtask

  // Idle and unmodulated, the subcarrier output shows the bare half period.
  task automatic t_subc();
    logic s;
    int   n;
    n = 0;
    s = cmd.subc;
    while (cmd.subc === s && n < 4000) begin
      @(posedge clk);
      n++;
    end
    s = cmd.subc;
    n = 0;
    while (cmd.subc === s && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("subcarrier half period", `SUBC_HALF_CYC, n);
  endtask

  task automatic t_config();
    cfg_t c;
    c = {16'hFFFF, 16'h6040, 16'h0020, 16'h0002, 16'h0064};
    cfg(c);
    repeat (3) @(posedge clk);
    chk("detached enables", 32'h07, pins());
    fresh_status();
    check_status(c);
  endtask

  task automatic t_reinit();
    cfg({16'h00FF, 16'h1020, 16'h0040, 16'h0003, 16'h0025});
    repeat (3) @(posedge clk);
    chk("reinit enables", 32'h10, pins());
    fresh_status();
    check_status(dflt);
  endtask

  task automatic t_reject();
    xfer(`A_VAL_MASK, 1'b1, 16'h8000);
    xfer(`A_VAL_MATCH, 1'b1, 16'h0000);
    xfer(`A_CMD_WORD, 1'b1, 16'h1234);
    xfer(`A_CMD_WORD, 1'b0, 16'h0000);
    chk("command count", 32'h1, q);
    cfg({`DEF_W4, `DEF_W3, 16'h8010, `DEF_W1, 16'h0004});
    repeat (3) @(posedge clk);
    chk("enables kept", 32'h10, pins());
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("reject flag", 32'h1, 32'(q[`F_CTL_CLR]));
    xfer(`A_CMD_WORD, 1'b0, 16'h0000);
    chk("command count cleared", 32'h0, q);
    fresh_status();
    xfer(`A_STATUS0, 1'b0, 16'h0000);
    chk("status0 reject", 32'h8000, q);
    xfer(`A_CMD_CTRL, 1'b1, 16'h0002);
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("reject cleared", 32'h0, 32'(q[`F_CTL_CLR]));
    xfer(`A_VAL_MASK, 1'b1, 16'h0000);
  endtask

  task automatic t_send();
    logic [19:0] got;
    int          n;
    cfg({`DEF_W4, `DEF_W3, `DEF_W2, 16'h0002, 16'h0002});
    xfer(`A_CMD_WORD, 1'b1, 16'hA5C3);
    xfer(`A_CMD_CTRL, 1'b1, 16'h0001);
    n = 0;
    while (line !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    repeat (100) @(posedge clk);
    for (int i = 19; i >= 0; i--) begin
      got[i] = line;
      repeat (200) @(posedge clk);
    end
    chk("line bits", {12'h000, 16'hA5C3, 4'hA}, {12'h000, got});
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("busy after send", 32'h0, 32'(q[`F_CTL_GO]));
  endtask

  task automatic t_abort();
    cfg({`DEF_W4, `DEF_W3, `DEF_W2, 16'h0002, 16'h0000});
    xfer(`A_CMD_WORD, 1'b1, 16'hFFFF);
    xfer(`A_CMD_CTRL, 1'b1, 16'h0001);
    repeat (300) @(posedge clk);
    cfg({`DEF_W4, `DEF_W3, 16'h0020, 16'h0002, 16'h0000});
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("abort flags", 32'h2, 32'(q[1:0]));
    xfer(`A_CMD_CTRL, 1'b1, 16'h0002);
  endtask

  task automatic t_fresh();
    fresh_status();
    xfer(`A_STATUS0, 1'b0, 16'h0000);
    repeat (1900) @(posedge clk);
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("fresh too early", 32'h0, 32'(q[`F_CTL_FRESH]));
    repeat (150) @(posedge clk);
    xfer(`A_CMD_CTRL, 1'b0, 16'h0000);
    chk("fresh after period", 32'h1, 32'(q[`F_CTL_FRESH]));
  endtask

  // Biphase coding: a one is high then low, a zero low then high, sampled per half bit.
  task automatic t_biphase();
    logic [7:0] got_a;
    logic [7:0] got_r;
    int         n;
    cfg({`DEF_W4, `DEF_W3, `DEF_W2, 16'h0002, 16'h0008});
    xfer(`A_CMD_WORD, 1'b1, 16'hA000);
    xfer(`A_CMD_CTRL, 1'b1, 16'h0001);
    n = 0;
    while (line !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    repeat (50) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      got_a[i] = line;
      got_r[i] = cmd.rf;
      repeat (100) @(posedge clk);
    end
    chk("biphase line", 32'h99, {24'h0, got_a});
    chk("rf line", 32'h99, {24'h0, got_r});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_path();
    t_subc();
    t_config();
    t_reinit();
    t_reject();
    t_send();
    t_abort();
    t_biphase();
    t_fresh();
    end_of_test();
  end
endmodule

// ---- pcmd_cfg.svh ----
`ifndef PCMD_CFG_SVH
`define PCMD_CFG_SVH

// Timing.
`define CLK_NS         10
`define TICK_NS        1000
`define TICK_CYC       (`TICK_NS / `CLK_NS)
`define SUBC_HALF_NS   31250
`define SUBC_HALF_CYC  (`SUBC_HALF_NS / `CLK_NS)
`define STATUS_MS      80

// Register byte offsets.
`define A_CFG_WORD     8'h00
`define A_CMD_WORD     8'h04
`define A_CMD_CTRL     8'h08
`define A_VAL_MASK     8'h0C
`define A_VAL_MATCH    8'h10
`define A_STATUS0      8'h14
`define A_STATUS1      8'h18
`define A_STATUS2      8'h1C
`define A_STATUS3      8'h20
`define A_STATUS4      8'h24

// Config word 0 fields.
`define F_REINIT       0
`define F_IDLE_EN      1
`define F_DETACHED     2
`define F_BIPHASE      3
`define F_SC_MOD       4
`define F_SC_OUT_EN    5
`define F_SC_IN_EN     6
// Status word 0 flag positions.
`define F_ST_BUSY      14
`define F_ST_REJ       15
// Control and flag positions in the control register.
`define F_CTL_GO       0
`define F_CTL_CLR      1
`define F_CTL_FRESH    2

// Default configuration words.
`define DEF_W0         16'h0000
`define DEF_W1         16'h01F4
`define DEF_W2         16'h0010
`define DEF_W3         16'h6040
`define DEF_W4         16'hFFFF

`define CFG_WORDS      5
`define LAST_CFG_IDX   3'h4
`endif

// ---- pcmd_pkg.sv ----
package pcmd_pkg;
  typedef struct packed {
    logic [15:0] w4;
    logic [15:0] w3;
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } cfg_t;

  typedef struct packed {
    logic a;
    logic a_en;
    logic b;
    logic b_en;
    logic rf;
    logic rf_en;
    logic subc;
    logic subc_en;
    logic subc_in_en;
  } cmd_out_t;

  typedef enum logic [1:0] {TX_OFF, TX_SEND, TX_FILL} tx_state_t;
endpackage

// ---- vehicle_equip_model.sv ----
`timescale 1ns/1ps
module vehicle_equip_model (
  input  wire logic               core_clk_i,
  input  wire logic               use_b_i,
  input  wire pcmd_pkg::cmd_out_t cmd_i,
  output logic                    path_sel_o,
  output logic                    line_o
);
  import pcmd_pkg::*;

  always @(posedge core_clk_i) begin
    path_sel_o <= use_b_i;
  end

  // A path whose enable is low carries nothing the equipment may trust, so it reads as zero.
  assign line_o = path_sel_o ? (cmd_i.b & cmd_i.b_en) : (cmd_i.a & cmd_i.a_en);
endmodule
